// file: microsequencer.sv
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Next address from flow, branch, stack, trap, fork.
// - Branch ORs conditions into low three bits.
// - Source conditions held until instruction issues.
// - Result conditions held during hold microword.
// - Call increments pointer, pushes previous address.
// - Return ORs stack top, then pops.
// - Trap enable queued with destination pointer.
// - At retire, check conditions and microtrap.
// - Exception stalls one cycle, then forces issue.
// - Issue checks source pointer and list faults.
// - Issue checks memory and destination faults.
// - Trap lets offending instruction write results.
// - Fault suppresses results, then microtrap begins.
// - Highest interrupt dispatched only above current level.
// - Interrupt compare only at instruction fork.
// - Interrupt dispatch stalls one, forces issue.
// - Interval counter and soft interrupts kept locally.
// - Soft status scanned every cycle, bit is level.
// - Highest soft interrupt arbitrated with others.
// - Request register absent; status bits set directly.
// - Next-address field is twelve bits wide.
// - Thirty-one nonzero branch codes select three conditions.
// - Four-bit select enables trap classes.
module microsequencer #(
  parameter int          STACK_DEPTH = 8,
  parameter int          RQ_DEPTH    = 4,
  parameter logic [11:0] TRAP_ENTRY  = msq_pkg::TRAP_VECTOR,
  parameter logic [11:0] FAULT_ENTRY = msq_pkg::FAULT_VECTOR,
  parameter logic [11:0] INT_ENTRY   = msq_pkg::INT_VECTOR
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Microword fields
  input  wire logic [msq_pkg::UADDR_W-1:0]   next_address_field_i,
  input  wire logic [msq_pkg::NSEL_W-1:0]    next_address_select_i,
  input  wire logic [msq_pkg::BEN_W-1:0]     branch_enable_code_i,
  input  wire logic [msq_pkg::TRAP_SEL_W-1:0] trap_class_select_i,
  input  wire logic                          trap_check_en_i,
  // Instruction unit
  input  wire logic [msq_pkg::UADDR_W-1:0]   fork_addr_i,
  input  wire logic                          fork_valid_i,
  // Branch conditions
  input  wire logic [msq_pkg::COND_W-1:0]    src_cond_i,
  input  wire logic [msq_pkg::COND_W-1:0]    res_cond_i,
  input  wire logic                          hold_microword_i,
  // Issue and retire
  input  wire logic                          issue_req_i,
  input  wire logic [msq_pkg::DEST_W-1:0]    dest_ptr_i,
  input  wire logic                          src_ptr_fault_i,
  input  wire logic                          src_list_fault_i,
  input  wire logic                          dst_ptr_fault_i,
  input  wire logic                          op_write_i,
  input  wire logic                          mem_fault_i,
  input  wire logic                          mem_fault_valid_i,
  input  wire logic                          retire_i,
  input  wire logic [msq_pkg::TRAP_SEL_W-1:0] exc_cond_i,
  input  wire logic                          exc_is_fault_i,
  // Serial interrupt packet pin
  input  wire logic                          irq_serial_i,
  // Sequencer outputs
  output logic      [msq_pkg::UADDR_W-1:0]   micro_program_counter_o,
  output logic                               issue_grant_o,
  output logic                               issue_stall_o,
  output logic                               issue_force_o,
  output logic                               result_write_o,
  output logic                               trap_taken_o,
  output logic      [msq_pkg::DEST_W-1:0]    trap_dest_o
);
  import msq_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_STALL, ST_FORCE} seq_state_e;

  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam int RQ_W = $clog2(RQ_DEPTH);

  // Sequencer state
  logic [UADDR_W-1:0]   upc_reg, upc_next;
  seq_state_e           state_reg, state_next;
  logic [SP_W-1:0]      sp_reg;
  logic [UADDR_W-1:0]   stack_mem [STACK_DEPTH];
  logic [COND_W-1:0]    src_cond_reg, res_cond_reg;

  // Result queue: trap enable, class select, destination
  logic                 rq_en  [RQ_DEPTH];
  logic [TRAP_SEL_W-1:0] rq_cls [RQ_DEPTH];
  logic [DEST_W-1:0]    rq_dst [RQ_DEPTH];
  logic [RQ_W-1:0]      rq_wr_reg, rq_rd_reg;
  logic [RQ_W:0]        rq_cnt_reg;

  // Software-visible state
  logic [LVL_W-1:0]     ipl_reg;
  logic [31:1]          soft_irq_status_reg;
  logic [31:0]          timer_reload_reg, timer_cnt_reg;
  logic                 timer_pend_reg;
  logic                 hw_pend_reg;
  logic [PKT_BITS-1:0]  pkt_reg;
  logic                 ack_reg;
  logic [31:0]          dat_reg;

  // Serial receiver
  logic [2:0]           pin_sync_reg;
  logic                 pin_reg;
  logic                 rx_busy_reg;
  logic                 rx_phase_reg;
  logic [3:0]           rx_cnt_reg;
  logic [PKT_BITS-1:0]  rx_shift_reg;

  // Branch recipe: code picks one condition per low address bit
  function automatic logic [2:0] branch_bits(input logic [4:0] code,
                                             input logic [15:0] cond);
    logic [3:0] idx;
    branch_bits = 3'h0;
    for (int k = 0; k < 3; k++) begin
      idx = 4'(code[3:0] + 4'(5 * k));
      branch_bits[k] = cond[idx] ^ code[4];
    end
  endfunction

  // Highest set software interrupt level
  function automatic logic [4:0] top_soft(input logic [31:1] bits);
    top_soft = 5'h00;
    for (int n = 1; n < 32; n++) begin
      if (bits[n]) begin
        top_soft = 5'(n);
      end
    end
  endfunction

  // Branch target and stack top
  wire [15:0]         cond_all  = {res_cond_reg, src_cond_reg};
  wire                ben_on    = branch_enable_code_i != BEN_NONE;
  wire [2:0]          ben_or    = ben_on ?
                        branch_bits(branch_enable_code_i, cond_all) : 3'h0;
  wire [UADDR_W-1:0]  br_target = next_address_field_i |
                                  {9'h000, ben_or};
  wire [UADDR_W-1:0]  stack_top = stack_mem[sp_reg];
  wire [UADDR_W-1:0]  ret_addr  = stack_top | next_address_field_i;
  wire                running   = state_reg == ST_RUN;
  wire                advance   = running && !hold_microword_i;

  // Issue-time fault checks
  wire mem_wr_fault = op_write_i & mem_fault_valid_i & mem_fault_i;
  wire issue_fault  = running & issue_req_i &
                      (src_ptr_fault_i | src_list_fault_i |
                       dst_ptr_fault_i | mem_wr_fault);
  wire rq_full      = rq_cnt_reg == (RQ_W+1)'(RQ_DEPTH);
  wire rq_empty     = rq_cnt_reg == '0;
  assign issue_grant_o = issue_req_i & running & !issue_fault & !rq_full;

  // Retire-time exception check against the head entry
  wire retire_ok  = retire_i & !rq_empty;
  wire exc_hit    = rq_en[rq_rd_reg] &
                    |(exc_cond_i & rq_cls[rq_rd_reg]);
  wire retire_exc = running & retire_ok & exc_hit;
  wire exc_fault  = retire_exc & exc_is_fault_i;

  // Interrupt arbitration
  wire [LVL_W-1:0] soft_lvl  = top_soft(soft_irq_status_reg);
  wire [LVL_W-1:0] hw_lvl    = hw_pend_reg ? pkt_reg[LVL_W-1:0] : '0;
  wire [LVL_W-1:0] tmr_lvl   = timer_pend_reg ? TIMER_IPL : '0;
  wire [LVL_W-1:0] hs_lvl    = (hw_lvl > soft_lvl) ? hw_lvl : soft_lvl;
  wire [LVL_W-1:0] best_lvl  = (tmr_lvl > hs_lvl) ? tmr_lvl : hs_lvl;
  wire             pick_tmr  = tmr_lvl > hs_lvl;
  wire             pick_hw   = !pick_tmr && hw_lvl > soft_lvl;
  wire             pick_soft = !pick_tmr && !pick_hw;
  wire             fork_now  = advance && fork_valid_i &&
                               next_address_select_i == NSEL_FORK;
  wire             int_take  = fork_now && !retire_exc && !issue_fault &&
                               best_lvl > ipl_reg;
  wire             exc_any   = retire_exc | issue_fault;
  wire             redirect  = exc_any | int_take;

  // Stack operations only when the microword really advances
  wire do_call = advance && !redirect && next_address_select_i == NSEL_CALL;
  wire do_pop  = advance && !redirect && next_address_select_i == NSEL_POP;

  assign micro_program_counter_o = upc_reg;
  assign issue_stall_o  = state_reg == ST_STALL || rq_full;
  assign issue_force_o  = state_reg == ST_FORCE;
  assign result_write_o = retire_ok & !exc_fault;
  assign trap_taken_o   = retire_exc | issue_fault;
  assign trap_dest_o    = rq_dst[rq_rd_reg];

  // Next micro-address selection
  always_comb begin
    upc_next = upc_reg;
    if (exc_any) begin
      upc_next = (issue_fault | exc_fault) ? FAULT_ENTRY : TRAP_ENTRY;
    end else if (int_take) begin
      upc_next = INT_ENTRY;
    end else if (advance) begin
      unique case (next_address_select_i)
        NSEL_FORK: upc_next = fork_valid_i ? fork_addr_i : upc_reg;
        NSEL_NEXT: upc_next = br_target;
        NSEL_POP:  upc_next = ret_addr;
        NSEL_CALL: upc_next = next_address_field_i;
      endcase
    end
  end

  // Stall one cycle, then force issue
  always_comb begin
    unique case (state_reg)
      ST_RUN:   state_next = redirect ? ST_STALL : ST_RUN;
      ST_STALL: state_next = ST_FORCE;
      ST_FORCE: state_next = ST_RUN;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upc_reg   <= '0;
      state_reg <= ST_RUN;
      sp_reg    <= '0;
    end else begin
      upc_reg   <= upc_next;
      state_reg <= state_next;
      if (do_call) begin
        sp_reg <= sp_reg + 1'b1;
      end else if (do_pop) begin
        sp_reg <= sp_reg - 1'b1;
      end
    end
  end

  // Microstack storage
  always_ff @(posedge clk_i) begin
    if (do_call) begin
      stack_mem[SP_W'(sp_reg + 1'b1)] <= upc_reg;
    end
  end

  // Condition latches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_cond_reg <= '0;
      res_cond_reg <= '0;
    end else begin
      if (issue_grant_o) begin
        src_cond_reg <= src_cond_i;
      end
      if (!hold_microword_i) begin
        res_cond_reg <= res_cond_i;
      end
    end
  end

  // Result queue of trap enables
  always_ff @(posedge clk_i) begin
    if (issue_grant_o) begin
      rq_en[rq_wr_reg]  <= trap_check_en_i;
      rq_cls[rq_wr_reg] <= trap_class_select_i;
      rq_dst[rq_wr_reg] <= dest_ptr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rq_wr_reg  <= '0;
      rq_rd_reg  <= '0;
      rq_cnt_reg <= '0;
    end else begin
      if (issue_grant_o) begin
        rq_wr_reg <= rq_wr_reg + 1'b1;
      end
      if (retire_ok) begin
        rq_rd_reg <= rq_rd_reg + 1'b1;
      end
      rq_cnt_reg <= rq_cnt_reg + (RQ_W+1)'(issue_grant_o)
                               - (RQ_W+1)'(retire_ok);
    end
  end

  // Serial packet pin synchroniser and agreement filter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sync_reg <= 3'h0;
      pin_reg      <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], irq_serial_i};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_reg <= pin_sync_reg[2];
      end
    end
  end

  // Packet receiver: start bit, then one bit every second clock, since
  // the agreement filter only passes bits that last two clocks
  wire rx_take = rx_busy_reg && rx_phase_reg;
  wire rx_done = rx_take && rx_cnt_reg == 4'(PKT_BITS - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_busy_reg  <= 1'b0;
      rx_phase_reg <= 1'b0;
      rx_cnt_reg   <= 4'h0;
      rx_shift_reg <= '0;
      pkt_reg      <= '0;
    end else if (!rx_busy_reg) begin
      // Phase left set after a packet masks the tail of its last bit
      rx_busy_reg  <= pin_reg & !rx_phase_reg;
      rx_phase_reg <= 1'b0;
      rx_cnt_reg   <= 4'h0;
    end else begin
      rx_phase_reg <= !rx_phase_reg | rx_done;
      if (rx_take) begin
        rx_shift_reg <= {rx_shift_reg[PKT_BITS-2:0], pin_reg};
        rx_cnt_reg   <= rx_cnt_reg + 4'h1;
      end
      if (rx_done) begin
        rx_busy_reg <= 1'b0;
        pkt_reg     <= {rx_shift_reg[PKT_BITS-2:0], pin_reg};
      end
    end
  end

  // Interrupt pending flags: a new request wins over dispatch
  wire take_hw   = int_take & pick_hw;
  wire take_tmr  = int_take & pick_tmr;
  wire take_soft = int_take & pick_soft;
  wire tmr_fire  = timer_reload_reg != '0 && timer_cnt_reg == 32'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hw_pend_reg    <= 1'b0;
      timer_pend_reg <= 1'b0;
    end else begin
      hw_pend_reg    <= rx_done | (hw_pend_reg & !take_hw);
      timer_pend_reg <= tmr_fire | (timer_pend_reg & !take_tmr);
    end
  end

  // Local interval counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_cnt_reg <= TIMER_RST;
    end else if (timer_reload_reg == '0) begin
      timer_cnt_reg <= TIMER_RST;
    end else if (timer_cnt_reg <= 32'h1) begin
      timer_cnt_reg <= timer_reload_reg;
    end else begin
      timer_cnt_reg <= timer_cnt_reg - 32'h1;
    end
  end

  // Wishbone decode
  wire        wb_req  = wb_cyc_i & wb_stb_i & !ack_reg;
  wire        wb_wr   = wb_req & wb_we_i;
  wire        sel_ipl = wb_adr_i == REG_IPL_OFS;
  wire        sel_sis = wb_adr_i == REG_SOFT_IRQ_STATUS_OFS;
  wire        sel_tmr = wb_adr_i == REG_TIMER_OFS;
  wire        sel_sts = wb_adr_i == REG_STATUS_OFS;
  wire        sel_pkt = wb_adr_i == REG_PACKET_OFS;
  wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] sis_set = (wb_wr && sel_sis) ? (wb_dat_i & wmask) : '0;
  wire [31:0] sis_clr = take_soft ? (32'h1 << soft_lvl) : '0;
  wire [31:0] status_word = {4'h0, 2'(state_reg), 1'(hw_pend_reg),
                             1'(timer_pend_reg), 3'(rq_cnt_reg), best_lvl,
                             4'(sp_reg), upc_reg};
  wire [31:0] rd_mux =
    sel_ipl ? {27'h0, ipl_reg} :
    sel_sis ? {soft_irq_status_reg, 1'b0} :
    sel_tmr ? timer_reload_reg :
    sel_sts ? status_word :
    sel_pkt ? {21'h0, pkt_reg} : 32'h0;

  // Software registers; soft status is write-one-to-set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ipl_reg          <= IPL_RST;
      soft_irq_status_reg         <= '0;
      timer_reload_reg <= TIMER_RST;
    end else begin
      soft_irq_status_reg <= (soft_irq_status_reg & ~sis_clr[31:1]) | sis_set[31:1];
      if (wb_wr && sel_ipl && wb_sel_i[0]) begin
        ipl_reg <= wb_dat_i[LVL_W-1:0];
      end
      if (wb_wr && sel_tmr) begin
        timer_reload_reg <= (timer_reload_reg & ~wmask) |
                            (wb_dat_i & wmask);
      end
    end
  end

  // Bus answer: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= wb_req;
      dat_reg <= wb_req ? rd_mux : dat_reg;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stall_force;
    issue_stall_o ##1 issue_force_o;
  endsequence

  a_exc_stall_force: assert property (
    exc_any |=> s_stall_force
  ) else $error("exception did not stall then force");

  a_int_stall_force: assert property (
    int_take |=> state_reg == ST_STALL ##1 state_reg == ST_FORCE
                 ##1 state_reg == ST_RUN
  ) else $error("interrupt dispatch sequence wrong");

  a_int_above_ipl: assert property (
    int_take |=> upc_reg == INT_ENTRY && $past(best_lvl) > $past(ipl_reg)
  ) else $error("interrupt taken at or below level");

  a_int_at_fork: assert property (
    upc_reg != INT_ENTRY ##1 upc_reg == INT_ENTRY && issue_stall_o
    |-> $past(fork_now)
  ) else $error("interrupt taken outside fork");

  a_call_push: assert property (
    do_call |=> sp_reg == SP_W'($past(sp_reg) + 1'b1) &&
                stack_mem[sp_reg] == $past(upc_reg)
  ) else $error("call did not push previous address");

  a_ret_or: assert property (
    do_pop |=> upc_reg == $past(ret_addr) &&
               sp_reg == SP_W'($past(sp_reg) - 1'b1)
  ) else $error("return address or pop wrong");

  a_branch_low: assert property (
    advance && !redirect && next_address_select_i == NSEL_NEXT
    |=> upc_reg[11:3] == $past(next_address_field_i[11:3])
  ) else $error("branch altered high address bits");

  a_fault_no_wr: assert property (
    exc_fault |-> !result_write_o ##1 upc_reg == FAULT_ENTRY
  ) else $error("fault wrote results");

  a_trap_writes: assert property (
    retire_exc && !exc_is_fault_i |-> result_write_o ##1
    upc_reg == TRAP_ENTRY
  ) else $error("trap did not complete instruction");

  a_issue_fault: assert property (
    issue_fault |-> !issue_grant_o ##1 upc_reg == FAULT_ENTRY
  ) else $error("faulting instruction issued");

  a_src_hold: assert property (
    !issue_grant_o |=> $stable(src_cond_reg)
  ) else $error("source conditions changed without issue");

  a_wb_ack: assert property (
    wb_req |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("bus ack not a single cycle");
endmodule

// file: msq_pkg.sv
package msq_pkg;
  // Microword field widths
  localparam int UADDR_W    = 12;
  localparam int BEN_W      = 5;
  localparam int TRAP_SEL_W = 4;
  localparam int NSEL_W     = 2;
  localparam int LVL_W      = 5;
  localparam int COND_W     = 8;
  localparam int DEST_W     = 8;

  // Next-address select encodings
  localparam logic [1:0] NSEL_FORK = 2'h0;
  localparam logic [1:0] NSEL_NEXT = 2'h1;
  localparam logic [1:0] NSEL_POP  = 2'h2;
  localparam logic [1:0] NSEL_CALL = 2'h3;

  // Branch-enable code that means no branch
  localparam logic [4:0] BEN_NONE = 5'h00;

  // Register byte offsets
  localparam logic [7:0] REG_IPL_OFS    = 8'h00;
  localparam logic [7:0] REG_SOFT_IRQ_STATUS_OFS   = 8'h04;
  localparam logic [7:0] REG_TIMER_OFS  = 8'h08;
  localparam logic [7:0] REG_STATUS_OFS = 8'h0C;
  localparam logic [7:0] REG_PACKET_OFS = 8'h10;

  // Reset values
  localparam logic [4:0]  IPL_RST   = 5'h1F;
  localparam logic [31:0] TIMER_RST = 32'h0000_0000;

  // Serial interrupt packet: start bit, then type, source, level
  localparam int PKT_TYPE_W = 2;
  localparam int PKT_SRC_W  = 4;
  localparam int PKT_BITS   = PKT_TYPE_W + PKT_SRC_W + LVL_W;

  // Fixed levels and entry points
  localparam logic [4:0]  TIMER_IPL    = 5'h18;
  localparam logic [11:0] TRAP_VECTOR  = 12'h010;
  localparam logic [11:0] FAULT_VECTOR = 12'h020;
  localparam logic [11:0] INT_VECTOR   = 12'h030;
endpackage

// file: sys_if_model.sv
`timescale 1ns/1ps
// Far-side sender of serial interrupt packets
module sys_if_model (
  // Clock and packet pin
  input  wire logic clk_i,
  output logic      irq_serial_o
);
  import msq_pkg::*;
  // Line rests low outside packets
  initial irq_serial_o = 1'b0;
  // Start bit, type, source and level, MSB first
  // Each bit, the closing idle bit too, lasts two clocks for the filter
  task automatic send(input logic [PKT_BITS-1:0] pkt);
    logic [PKT_BITS+1:0] frame;
    frame = {1'b1, pkt, 1'b0};
    for (int i = PKT_BITS + 1; i >= 0; i--) begin
      repeat (2) @(posedge clk_i) irq_serial_o <= frame[i];
    end
  endtask
endmodule

// file: tb_microsequencer.sv
`timescale 1ns/1ps
module tb_microsequencer;
  import msq_pkg::*;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
    fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
    end end
  // Stimulus and observed signals
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0, trap_check_en_i = 1'b0, fork_valid_i = 1'b0;
  logic        issue_req_i = 1'b0, retire_i = 1'b0, exc_is_fault_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, dest_ptr_i = 8'h00, trap_dest_o;
  logic [3:0]  trap_class_select_i = 4'h0, exc_cond_i = 4'h0, flt = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_r, exp_q[$];
  logic [7:0]  src_cond_i = 8'h00, res_cond_i = 8'h00;
  logic        hold_microword_i = 1'b0;
  logic [11:0] next_address_field_i = 12'h000, fork_addr_i = 12'h000;
  logic [11:0] micro_program_counter_o;
  logic [1:0]  next_address_select_i = NSEL_NEXT;
  logic [4:0]  branch_enable_code_i = BEN_NONE;
  logic        irq_serial_i, wb_ack_o, issue_grant_o, issue_stall_o;
  logic        issue_force_o, result_write_o, trap_taken_o;
  int          n_checks = 0, fail_count = 0;
  // 125 MHz clock
  always #4 clk_i = ~clk_i;
  microsequencer uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .next_address_field_i, .next_address_select_i, .branch_enable_code_i,
    .trap_class_select_i, .trap_check_en_i, .fork_addr_i, .fork_valid_i,
    .src_cond_i, .res_cond_i, .hold_microword_i,
    .issue_req_i, .dest_ptr_i, .src_ptr_fault_i(flt[0]),
    .src_list_fault_i(flt[1]), .dst_ptr_fault_i(flt[2]), .op_write_i(flt[3]),
    .mem_fault_i(flt[3]), .mem_fault_valid_i(flt[3]), .retire_i, .exc_cond_i,
    .exc_is_fault_i, .irq_serial_i, .micro_program_counter_o, .issue_grant_o,
    .issue_stall_o, .issue_force_o, .result_write_o, .trap_taken_o,
    .trap_dest_o);
  sys_if_model sif (.clk_i, .irq_serial_o(irq_serial_i));
  // Read results checked against the oldest note
  always @(negedge clk_i) if (wb_ack_o === 1'b1 && !wb_we_i) begin
    exp_r = exp_q.pop_front();
    `CHK(wb_dat_o, exp_r)
  end
  // Classic single cycle; on a read d is the expected data
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    if (!w) exp_q.push_back(d);
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // Instruction fork held for one cycle
  task automatic fork_to(input logic [11:0] a);
    @(posedge clk_i);
    {next_address_select_i, fork_valid_i, fork_addr_i} <= {NSEL_FORK, 1'b1, a};
    @(posedge clk_i);
    {next_address_select_i, fork_valid_i} <= {NSEL_NEXT, 1'b0};
  endtask
  // Entry, one stall cycle, then one forced issue
  task automatic redirect(input logic [11:0] entry);
    @(negedge clk_i);
    `CHK(micro_program_counter_o, entry)
    `CHK(issue_stall_o, 1'b1)
    @(negedge clk_i);
    `CHK(issue_force_o, 1'b1)
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [11:0] r, s, fa;
    logic [7:0]  d, sc, rc;
    void'($urandom(66726));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, REG_IPL_OFS, {27'h0, IPL_RST});
    wb(1, 8'h80, 32'hFFFF_FFFF);
    wb(0, 8'h80, 32'h0);
    wb(0, REG_SOFT_IRQ_STATUS_OFS, 32'h0);
    $display("test registers done");
    r = 12'($urandom) & 12'hFF8;
    s = 12'($urandom);
    @(posedge clk_i) next_address_field_i <= r;
    @(posedge clk_i) {next_address_select_i, next_address_field_i} <= {NSEL_CALL, s};
    @(negedge clk_i) `CHK(micro_program_counter_o, r)
    @(posedge clk_i) {next_address_select_i, next_address_field_i} <= {NSEL_POP, 12'h000};
    @(negedge clk_i) `CHK(micro_program_counter_o, s)
    @(posedge clk_i) {next_address_select_i, next_address_field_i} <= {NSEL_NEXT, 12'h100};
    branch_enable_code_i <= 5'h10;
    @(negedge clk_i) `CHK(micro_program_counter_o, r)
    @(posedge clk_i) branch_enable_code_i <= BEN_NONE;
    @(negedge clk_i) `CHK(micro_program_counter_o, 12'h107)
    // Conditions latched at issue, then held by no issue and by hold
    sc = 8'($urandom);
    rc = 8'($urandom);
    @(posedge clk_i) {src_cond_i, res_cond_i, issue_req_i} <= {sc, rc, 1'b1};
    @(posedge clk_i) begin
      {src_cond_i, res_cond_i} <= {~sc, ~rc};
      {issue_req_i, retire_i, hold_microword_i} <= 3'b011;
    end
    @(posedge clk_i) begin
      {retire_i, hold_microword_i} <= 2'b00;
      branch_enable_code_i <= 5'h01;
    end
    @(posedge clk_i) branch_enable_code_i <= BEN_NONE;
    r = {9'h020, rc[3], sc[6], sc[1]};
    @(negedge clk_i) `CHK(micro_program_counter_o, r)
    $display("test flow done");
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      @(posedge clk_i);
      {issue_req_i, trap_check_en_i, dest_ptr_i} <= {2'b11, d};
      trap_class_select_i <= (i == 2) ? 4'h1 : 4'hF;
      @(negedge clk_i) `CHK(issue_grant_o, 1'b1)
      @(posedge clk_i);
      {issue_req_i, retire_i, exc_cond_i, exc_is_fault_i} <= {2'b01, 4'h2, i == 1};
      @(negedge clk_i) `CHK(trap_taken_o, i != 2)
      `CHK(result_write_o, i != 1)
      `CHK(trap_dest_o, d)
      @(posedge clk_i) {retire_i, exc_cond_i} <= 5'h00;
      if (i < 2) redirect(i ? FAULT_VECTOR : TRAP_VECTOR);
    end
    for (int j = 0; j < 4; j++) begin
      @(posedge clk_i) {issue_req_i, flt} <= {1'b1, 4'b1 << j};
      @(negedge clk_i) `CHK(issue_grant_o, 1'b0)
      @(posedge clk_i) {issue_req_i, flt} <= 5'h00;
      redirect(FAULT_VECTOR);
    end
    $display("test exceptions done");
    sif.send({2'h1, 4'hA, 5'h03});
    repeat (8) @(posedge clk_i);
    wb(0, REG_PACKET_OFS, {21'h0, 2'h1, 4'hA, 5'h03});
    wb(1, REG_SOFT_IRQ_STATUS_OFS, 32'h4);
    wb(0, REG_SOFT_IRQ_STATUS_OFS, 32'h4);
    wb(1, REG_IPL_OFS, 32'h4);
    fa = 12'($urandom);
    fork_to(fa);
    @(negedge clk_i) `CHK(micro_program_counter_o, fa)
    fork_to(FAULT_VECTOR);
    @(negedge clk_i) `CHK(micro_program_counter_o, FAULT_VECTOR)
    wb(1, REG_IPL_OFS, 32'h2);
    @(negedge clk_i) `CHK(micro_program_counter_o, 12'h100)
    fork_to(fa);
    redirect(INT_VECTOR);
    wb(1, REG_IPL_OFS, 32'h1);
    fork_to(fa);
    redirect(INT_VECTOR);
    wb(0, REG_SOFT_IRQ_STATUS_OFS, 32'h0);
    wb(1, REG_TIMER_OFS, 32'h3);
    wb(0, REG_TIMER_OFS, 32'h3);
    fork_to(fa);
    redirect(INT_VECTOR);
    wb(1, REG_TIMER_OFS, 32'h0);
    $display("test interrupts done");
    summarize();
  end
endmodule
